// [include/hmsd_pkg.sv]
// What this block does
// (RULE1) Aux clock driven only when enabled, host mode.
// (RULE2) Mode strap: low hardware, mid serial, high parallel.
// (RULE3) Parallel mode: mux pin high selects shared bus.
// (RULE4) Hardware mode impedance pin picks termination.
// (RULE5) 120 ohm variant inverts E1 impedance only.
// (RULE6) Parallel mode: bus style pin picks strobes.
// (RULE7) Hardware mode code pin: AMI high, else B8ZS/HDB3.
// (RULE8) Host keeps chip select low during accesses.
// (RULE9) Jitter strap: low transmit, mid off, high receive. Decoded only in hardware mode; off in host modes.
// (RULE10) Straps synchronised; mode held after reset release.
package hmsd_pkg;
  // Register offsets on the plain register port.
  localparam logic [5:0] MCR_OFS = 6'h00;
  localparam logic [5:0] CCR_OFS = 6'h01;
  localparam logic [5:0] STAT_OFS = 6'h02;
  // Field positions.
  localparam int MCR_AUX_EN_BIT = 0;
  localparam int CCR_DIV_LSB = 0;
  localparam int CCR_DIV_W = 4;
  localparam int STAT_VALID_BIT = 2;
  // Reset values.
  localparam logic [7:0] MCR_RST = 8'h00;
  localparam logic [7:0] CCR_RST = 8'h00;
  // Cycles from reset release until the mode strap is trusted.
  localparam logic [1:0] SETTLE_CYCLES = 2'h3;
  // Two-bit comparator codes of a three-level strap.
  localparam logic [1:0] STRAP_LOW = 2'h0;
  localparam logic [1:0] STRAP_MID = 2'h1;
  localparam logic [1:0] STRAP_HIGH = 2'h3;

  // Control modes selected by the mode strap.
  typedef enum logic [1:0] {HMSD_MODE_HW, HMSD_MODE_SERIAL, HMSD_MODE_PARALLEL} hmsd_mode_t;
  // Termination and receive match choices.
  typedef enum logic [1:0] {HMSD_IMP_75, HMSD_IMP_100, HMSD_IMP_110, HMSD_IMP_120} hmsd_imp_t;
  // Line codes.
  typedef enum logic [1:0] {HMSD_CODE_AMI, HMSD_CODE_B8ZS, HMSD_CODE_HDB3} hmsd_code_t;
  // Jitter attenuator placement.
  typedef enum logic [1:0] {HMSD_JA_TX, HMSD_JA_OFF, HMSD_JA_RX} hmsd_ja_t;

  // Maps a comparator code to a level: 0 low, 1 mid, 2 high.
  // An inconsistent code is taken as mid, the floating default.
  function automatic logic [1:0] hmsd_level(input logic [1:0] code);
    logic [1:0] lvl;
    lvl = 2'h1;
    if (code == STRAP_LOW) begin
      lvl = 2'h0;
    end else if (code == STRAP_HIGH) begin
      lvl = 2'h2;
    end
    return lvl;
  endfunction : hmsd_level
endpackage : hmsd_pkg

// [logic/hmsd_sync.sv]
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser for the strap comparator bits.
module hmsd_sync (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [3:0] d_i,
  output logic [3:0] q_o
);
  import hmsd_pkg::*;
  logic [3:0] meta_r; // First stage, read only by the second stage.

  // Both stages clear to the low level at reset.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      meta_r <= 4'h0;
      q_o <= 4'h0;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule : hmsd_sync
`default_nettype wire

// [logic/hmsd_top.sv]
`timescale 1ns/1ps
`default_nettype none
// Control-mode strap and dual-function pin decoder.
module hmsd_top #(
  parameter bit VARIANT_120 = 1'b0 // Set for the build that defaults to 120 ohm.
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [1:0] control_mode_strap_i,
  input wire logic [1:0] jitter_atten_place_select_i,
  input wire logic chip_select_n_i,
  input wire logic line_impedance_select_i,
  input wire logic bus_style_select_i,
  input wire logic e1_mode_i,
  input wire logic [5:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output hmsd_pkg::hmsd_mode_t mode_o,
  output logic mode_valid_o,
  output logic addr_data_mux_o,
  output logic sep_strobes_o,
  output hmsd_pkg::hmsd_imp_t impedance_o,
  output hmsd_pkg::hmsd_code_t line_code_o,
  output hmsd_pkg::hmsd_ja_t jitter_place_o,
  output logic aux_clock_out_o,
  output logic aux_clock_out_enable_o
);
  import hmsd_pkg::*;

  logic [3:0] strap_sync; // Synchronised mode and jitter comparator bits.
  logic [1:0] mode_lvl; // Level of the synchronised mode strap.
  logic [1:0] ja_lvl; // Level of the synchronised jitter strap.
  hmsd_mode_t mode_r, mode_nxt; // Captured control mode.
  logic valid_r, valid_nxt; // Mode has been captured.
  logic [1:0] settle_r, settle_nxt; // Cycles since reset release.
  logic [7:0] master_config_reg_r, master_config_reg_nxt;
  logic [7:0] clock_choice_reg_r, clock_choice_reg_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic mux_r, mux_nxt;
  logic strobes_r, strobes_nxt;
  hmsd_imp_t imp_r, imp_nxt;
  hmsd_code_t code_r, code_nxt;
  hmsd_ja_t ja_r, ja_nxt;
  logic [CCR_DIV_W-1:0] div_r, div_nxt; // Aux clock half-period counter.
  logic aux_r, aux_nxt;
  logic aux_oe_r, aux_oe_nxt;
  logic hw_mode; // Captured mode is hardware mode.
  logic host_ok; // Host mode with chip select asserted.
  logic aux_run; // Aux clock may toggle.

  // Straps pass through synchronisers before any decoding.
  hmsd_sync u_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .d_i({jitter_atten_place_select_i, control_mode_strap_i}),
    .q_o(strap_sync)
  );

  assign mode_lvl = hmsd_level(strap_sync[1:0]); // [RULE10]
  assign ja_lvl = hmsd_level(strap_sync[3:2]); // [RULE10]
  assign hw_mode = (mode_r == HMSD_MODE_HW);
  // Registers are reached only in a host mode while chip select is low.
  assign host_ok = valid_r && !hw_mode && !chip_select_n_i; // [RULE8]
  assign aux_run = master_config_reg_r[MCR_AUX_EN_BIT] && valid_r && !hw_mode;

  // Mode capture: waits for the synchroniser, then freezes the mode.
  always_comb begin
    settle_nxt = settle_r;
    valid_nxt = valid_r;
    mode_nxt = mode_r;
    if (!valid_r) begin
      if (settle_r == SETTLE_CYCLES) begin
        valid_nxt = 1'b1;
        // Low hardware, mid serial host, high parallel host.
        if (mode_lvl == 2'h0) begin // [RULE2]
          mode_nxt = HMSD_MODE_HW;
        end else if (mode_lvl == 2'h1) begin
          mode_nxt = HMSD_MODE_SERIAL;
        end else begin
          mode_nxt = HMSD_MODE_PARALLEL;
        end
      end else begin
        settle_nxt = settle_r + 2'h1;
      end
    end
  end

  // Mode state registers; the mode never changes once valid.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      settle_r <= 2'h0;
      valid_r <= 1'b0;
      mode_r <= HMSD_MODE_HW;
    end else begin
      settle_r <= settle_nxt;
      valid_r <= valid_nxt;
      mode_r <= mode_nxt; // [RULE10]
    end
  end

  // Register port: writes and reads accepted only through host_ok.
  always_comb begin
    master_config_reg_nxt = master_config_reg_r;
    clock_choice_reg_nxt = clock_choice_reg_r;
    rdata_nxt = 8'h00;
    if (reg_wr_i && host_ok) begin // [RULE8]
      if (reg_addr_i == MCR_OFS) begin
        master_config_reg_nxt = reg_wdata_i;
      end else if (reg_addr_i == CCR_OFS) begin
        clock_choice_reg_nxt = reg_wdata_i;
      end
    end
    if (reg_rd_i && host_ok) begin
      if (reg_addr_i == MCR_OFS) begin
        rdata_nxt = master_config_reg_r;
      end else if (reg_addr_i == CCR_OFS) begin
        rdata_nxt = clock_choice_reg_r;
      end else if (reg_addr_i == STAT_OFS) begin
        rdata_nxt = {5'h00, valid_r, mode_r};
      end
    end
  end

  // Register file flops; read data stand for one cycle only.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      master_config_reg_r <= MCR_RST;
      clock_choice_reg_r <= CCR_RST;
      rdata_r <= 8'h00;
    end else begin
      master_config_reg_r <= master_config_reg_nxt;
      clock_choice_reg_r <= clock_choice_reg_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Pin meanings, decoded from the captured mode every cycle.
  always_comb begin
    mux_nxt = 1'b0;
    strobes_nxt = 1'b0;
    imp_nxt = HMSD_IMP_75;
    code_nxt = HMSD_CODE_HDB3;
    ja_nxt = HMSD_JA_OFF;
    if (valid_r && mode_r == HMSD_MODE_PARALLEL) begin
      // High selects shared address/data lines.
      mux_nxt = line_impedance_select_i; // [RULE3]
      // Low: direction plus data strobe; high: read and write strobes.
      strobes_nxt = bus_style_select_i; // [RULE6]
    end else if (valid_r && hw_mode) begin
      if (e1_mode_i) begin
        // E1 choice between 75 and 120 ohm, flipped on the 120 build.
        if (line_impedance_select_i ^ VARIANT_120) begin // [RULE4] [RULE5]
          imp_nxt = HMSD_IMP_120;
        end else begin
          imp_nxt = HMSD_IMP_75;
        end
      end else begin
        // T1/J1 choice is the same on both builds.
        imp_nxt = line_impedance_select_i ? HMSD_IMP_110 : HMSD_IMP_100; // [RULE4]
      end
      if (bus_style_select_i) begin // [RULE7]
        code_nxt = HMSD_CODE_AMI;
      end else begin
        code_nxt = e1_mode_i ? HMSD_CODE_HDB3 : HMSD_CODE_B8ZS;
      end
      if (ja_lvl == 2'h0) begin // [RULE9]
        ja_nxt = HMSD_JA_TX;
      end else if (ja_lvl == 2'h2) begin
        ja_nxt = HMSD_JA_RX;
      end else begin
        ja_nxt = HMSD_JA_OFF;
      end
    end
  end

  // Decoded pin meaning flops.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      mux_r <= 1'b0;
      strobes_r <= 1'b0;
      imp_r <= HMSD_IMP_75;
      code_r <= HMSD_CODE_HDB3;
      ja_r <= HMSD_JA_OFF;
    end else begin
      mux_r <= mux_nxt;
      strobes_r <= strobes_nxt;
      imp_r <= imp_nxt;
      code_r <= code_nxt;
      ja_r <= ja_nxt;
    end
  end

  // Aux clock divider; it idles low and undriven unless enabled in host mode.
  always_comb begin
    div_nxt = 4'h0;
    aux_nxt = 1'b0;
    aux_oe_nxt = aux_run; // [RULE1]
    if (aux_run) begin
      if (div_r == clock_choice_reg_r[CCR_DIV_LSB +: CCR_DIV_W]) begin
        aux_nxt = !aux_r;
      end else begin
        div_nxt = div_r + 4'h1;
        aux_nxt = aux_r;
      end
    end
  end

  // Aux clock flops.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      div_r <= 4'h0;
      aux_r <= 1'b0;
      aux_oe_r <= 1'b0;
    end else begin
      div_r <= div_nxt;
      aux_r <= aux_nxt;
      aux_oe_r <= aux_oe_nxt;
    end
  end

  assign reg_rdata_o = rdata_r;
  assign mode_o = mode_r;
  assign mode_valid_o = valid_r;
  assign addr_data_mux_o = mux_r;
  assign sep_strobes_o = strobes_r;
  assign impedance_o = imp_r;
  assign line_code_o = code_r;
  assign jitter_place_o = ja_r;
  assign aux_clock_out_o = aux_r;
  assign aux_clock_out_enable_o = aux_oe_r;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  // Three cycles of a steady strap level in hardware mode.
  sequence ja_high_s;
    (valid_r && hw_mode && jitter_atten_place_select_i == STRAP_HIGH)[*3];
  endsequence
  // A status read accepted from the host.
  sequence stat_rd_s;
    reg_rd_i && host_ok && reg_addr_i == STAT_OFS;
  endsequence

  aux_hw_off_a: assert property (hw_mode |-> !aux_clock_out_enable_o) // [RULE1]
    else $error("aux clock driven in hardware mode");
  aux_enabled_a: assert property (aux_run |=> aux_clock_out_enable_o) // [RULE1]
    else $error("aux clock not driven when enabled");
  mode_decode_a: assert property ($rose(valid_r) // [RULE2]
    |-> mode_r == hmsd_mode_t'($past(mode_lvl)))
    else $error("control mode misdecoded");
  mode_hold_a: assert property (valid_r ##1 valid_r |-> $stable(mode_r)) // [RULE10]
    else $error("control mode changed after capture");
  bus_mux_a: assert property (valid_r && mode_r == HMSD_MODE_PARALLEL // [RULE3]
    |=> mux_r == $past(line_impedance_select_i))
    else $error("address mux select wrong");
  imp_e1_a: assert property (valid_r && hw_mode && e1_mode_i // [RULE5]
    && (line_impedance_select_i ^ VARIANT_120) |=> imp_r == HMSD_IMP_120)
    else $error("E1 impedance wrong");
  imp_t1_a: assert property (valid_r && hw_mode && !e1_mode_i // [RULE4]
    && !line_impedance_select_i |=> imp_r == HMSD_IMP_100)
    else $error("T1 impedance wrong");
  bus_style_a: assert property (valid_r && mode_r == HMSD_MODE_PARALLEL // [RULE6]
    |=> strobes_r == $past(bus_style_select_i))
    else $error("bus style wrong");
  line_code_a: assert property (valid_r && hw_mode && bus_style_select_i // [RULE7]
    |=> code_r == HMSD_CODE_AMI)
    else $error("line code not AMI");
  ja_place_a: assert property (ja_high_s |=> ja_r == HMSD_JA_RX) // [RULE9]
    else $error("jitter attenuator not in receive path");
  cs_gate_a: assert property (reg_wr_i && chip_select_n_i // [RULE8]
    |=> $stable(master_config_reg_r))
    else $error("write taken without chip select");
  stat_read_a: assert property (stat_rd_s // [RULE2]
    |=> reg_rdata_o[1:0] == mode_r && reg_rdata_o[2])
    else $error("status read wrong");
endmodule : hmsd_top
`default_nettype wire

// [verif/hmsd_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Board straps and host chip select seen from the decoder's far side.
module hmsd_host_model (
  input wire logic [1:0] mode_lvl_i, // Strap level: 0 low, 1 mid, 2 high.
  input wire logic [1:0] ja_lvl_i, // Jitter strap level, same coding.
  input wire logic acc_i, // High while the host runs a register access.
  input wire logic cs_break_i, // High when a scenario wants select left off.
  output logic [1:0] mode_code_o,
  output logic [1:0] ja_code_o,
  output logic chip_select_n_o
);
  // Turns a strap level into the comparator pair a real strap would give.
  function automatic logic [1:0] to_code(input logic [1:0] lvl);
    return (lvl == 2'h0) ? 2'h0 : ((lvl == 2'h1) ? 2'h1 : 2'h3);
  endfunction : to_code
  assign mode_code_o = to_code(mode_lvl_i);
  assign ja_code_o = to_code(ja_lvl_i);
  // Select is held low for the whole access unless told otherwise.
  assign chip_select_n_o = ~(acc_i & ~cs_break_i);
endmodule : hmsd_host_model
`default_nettype wire

// [verif/tb.sv]
`timescale 1ns/1ps
`default_nettype none
// Walks the decoder through hardware, serial and parallel control modes.
module tb;
  import hmsd_pkg::*;
  logic clock_i = 1'b0, rst_i = 1'b1, acc = 1'b0, cs_break = 1'b0;
  logic imp_pin = 1'b0, style_pin = 1'b0, e1 = 1'b0, wr = 1'b0, rd = 1'b0, prev;
  logic [1:0] mlvl = 2'h0, jlvl = 2'h0;
  logic [5:0] addr = 6'h00;
  logic [7:0] wdata = 8'h00, rdata, exp_imp, exp_imp2, exp_code;
  wire logic [1:0] mcode, jcode;
  wire logic csn;
  logic valid, mux, sep, aux, oe;
  hmsd_mode_t mode;
  hmsd_imp_t imp, imp2;
  hmsd_code_t code;
  hmsd_ja_t ja;
  int error_cnt = 0, n_tests = 0, cyc = 0, tog;

  // The clock toggles every half period of 2 ns.
  always #2 clock_i = ~clock_i;

  hmsd_host_model host (.mode_lvl_i(mlvl), .ja_lvl_i(jlvl), .acc_i(acc),
    .cs_break_i(cs_break), .mode_code_o(mcode), .ja_code_o(jcode), .chip_select_n_o(csn));
  hmsd_top dut (.clock_i(clock_i), .rst_i(rst_i), .control_mode_strap_i(mcode),
    .jitter_atten_place_select_i(jcode), .chip_select_n_i(csn),
    .line_impedance_select_i(imp_pin), .bus_style_select_i(style_pin), .e1_mode_i(e1),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .mode_o(mode), .mode_valid_o(valid), .addr_data_mux_o(mux),
    .sep_strobes_o(sep), .impedance_o(imp), .line_code_o(code), .jitter_place_o(ja),
    .aux_clock_out_o(aux), .aux_clock_out_enable_o(oe));
  // Second build, defaulting to 120 ohm; only its impedance is watched.
  hmsd_top #(.VARIANT_120(1'b1)) dut_v120 (.clock_i(clock_i), .rst_i(rst_i),
    .control_mode_strap_i(mcode), .jitter_atten_place_select_i(jcode),
    .chip_select_n_i(csn), .line_impedance_select_i(imp_pin), .bus_style_select_i(style_pin),
    .e1_mode_i(e1), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(), .mode_o(), .mode_valid_o(), .addr_data_mux_o(), .sep_strobes_o(),
    .impedance_o(imp2), .line_code_o(), .jitter_place_o(), .aux_clock_out_o(),
    .aux_clock_out_enable_o());

  // Prints the verdict and ends the run.
  task tally_and_finish;
    if (error_cnt == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  // Compares one value and reports a difference at once.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Holds reset for four cycles with the mode strap set, then lets it settle.
  task automatic do_reset(input logic [1:0] lvl);
    @(posedge clock_i);
    mlvl <= lvl;
    rst_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (8) @(posedge clock_i);
    #1;
  endtask : do_reset

  // One-cycle register write.
  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    acc <= 1'b1;
    @(posedge clock_i);
    wr <= 1'b0;
    acc <= 1'b0;
  endtask : wr_reg

  // One-cycle register read; data is sampled in the cycle after the strobe.
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
    @(posedge clock_i);
    addr <= a;
    rd <= 1'b1;
    acc <= 1'b1;
    @(posedge clock_i);
    rd <= 1'b0;
    acc <= 1'b0;
    #1;
    check(rdata, exp);
  endtask : rd_chk

  // Cuts a hang short well beyond the expected run length.
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  initial begin
    // Hardware mode: shared pins carry the line functions.
    do_reset(2'h0);
    check({6'h00, mode}, {6'h00, HMSD_MODE_HW});
    check({7'h00, valid}, 8'h01);
    for (int i = 0; i < 4; i++) begin
      @(posedge clock_i);
      imp_pin <= i[1];
      style_pin <= i[1];
      e1 <= i[0];
      repeat (2) @(posedge clock_i);
      #1;
      exp_imp = i[1] ? (i[0] ? HMSD_IMP_120 : HMSD_IMP_110) : (i[0] ? HMSD_IMP_75 : HMSD_IMP_100);
      exp_imp2 = (i[0] == 1) ? (i[1] ? HMSD_IMP_75 : HMSD_IMP_120) : exp_imp;
      exp_code = i[1] ? HMSD_CODE_AMI : (i[0] ? HMSD_CODE_HDB3 : HMSD_CODE_B8ZS);
      check({6'h00, imp}, exp_imp);
      check({6'h00, imp2}, exp_imp2);
      check({6'h00, code}, exp_code);
    end
    // Each jitter strap level maps straight onto the placement code.
    for (int l = 0; l < 3; l++) begin
      @(posedge clock_i);
      jlvl <= l[1:0];
      repeat (4) @(posedge clock_i);
      #1;
      check({6'h00, ja}, 8'(l));
    end
    // A moved strap and a write attempt must change nothing here.
    @(posedge clock_i);
    mlvl <= 2'h2;
    wr_reg(MCR_OFS, 8'h01);
    rd_chk(STAT_OFS, 8'h00);
    check({6'h00, oe, aux}, 8'h00);
    check({6'h00, mode}, {6'h00, HMSD_MODE_HW});
    // Serial host mode: parallel-only pins are inert.
    do_reset(2'h1);
    rd_chk(STAT_OFS, 8'h05);
    check({6'h00, mux, sep}, 8'h00);
    check({6'h00, ja}, {6'h00, HMSD_JA_OFF});
    wr_reg(CCR_OFS, 8'h01);
    wr_reg(MCR_OFS, 8'h01);
    @(posedge clock_i);
    #1;
    check({7'h00, oe}, 8'h01);
    prev = aux;
    tog = 0;
    repeat (8) begin
      @(posedge clock_i);
      #1;
      tog += (aux !== prev) ? 1 : 0;
      prev = aux;
    end
    check(8'(tog), 8'h04);
    // Without chip select the disabling write is ignored.
    cs_break <= 1'b1;
    wr_reg(MCR_OFS, 8'h00);
    cs_break <= 1'b0;
    @(posedge clock_i);
    #1;
    check({7'h00, oe}, 8'h01);
    rd_chk(6'h3f, 8'h00);
    rd_chk(CCR_OFS, 8'h01);
    wr_reg(MCR_OFS, 8'h00);
    repeat (2) @(posedge clock_i);
    #1;
    check({6'h00, oe, aux}, 8'h00);
    // Parallel host mode: mux and bus style pins in all combinations.
    do_reset(2'h2);
    rd_chk(STAT_OFS, 8'h06);
    for (int i = 0; i < 4; i++) begin
      @(posedge clock_i);
      imp_pin <= i[0];
      style_pin <= i[1];
      repeat (2) @(posedge clock_i);
      #1;
      check({7'h00, mux}, 8'(i[0]));
      check({7'h00, sep}, 8'(i[1]));
    end
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
